/* File: rtl/hsb_device.sv */
// Behaviour
// - master moves 16 bits low, 32 full
// - slave reads drive low half only
// - drive word address after bus grant
// - host places index, strobes select low
// - latch select lines on address latch
// - reset state after ten clock cycles
// - host never overlaps select and memory request
// - two clocks between select and memory request
// - read cycle: data strobe low lets slave drive
// - write cycle: data strobe marks valid data
// - dma engine timed from bus clock
// - status lines show current bus operation
// - acknowledge low when access available
// - ordering select picks byte order (only reported on big_endian_out, data lanes are not reordered)
`timescale 1ns/10ps
`include "hsb_params.svh"
module hsb_device #(
   parameter int RESET_CYCLES = `HSB_RESET_CYCLES
) (
   // clock and reset (bus_side_clock)
   input  wire logic                     clk_in,
   input  wire logic                     rst_n_in,
   // system bus
   hsb_if.device                         bus,
   // dma request from user side
   input  wire logic                     dma_req_in,
   input  wire logic                     dma_write_in,
   input  wire logic                     dma_wide_in,
   input  wire logic [`HSB_ADDR_W-1:0]   dma_addr_in,
   input  wire logic [`HSB_DATA_W-1:0]   dma_wdata_in,
   output logic                          dma_done_out,
   output logic      [`HSB_DATA_W-1:0]   dma_rdata_out,
   // status
   output logic                          in_reset_out,
   output logic                          big_endian_out
);
   hsb_pkg::hsb_dev_state_e st_r;
   logic [3:0]                       rst_cnt_r;
   logic [`HSB_REG_SEL_W-1:0]        sel_r;
   logic [`HSB_HALF_W-1:0]           regs_r [`HSB_REG_COUNT];
   logic                             wr_r;
   logic                             wide_r;
   logic [`HSB_DATA_W-1:0]           wdat_r;
   logic [`HSB_ADDR_W-1:0]           addr_r;
   logic                             cs_s;
   logic                             shared_memory_request_s;
   logic                             sas_s;
   logic                             grant_s;
   logic                             order_s;
   logic                             swr_s;
   logic [`HSB_REG_SEL_W-1:0]        rsel_s;
   logic [`HSB_DATA_W-1:0]           data_s;
   logic                             slave_act;
   logic                             master_act;
   initial begin
      if (RESET_CYCLES < 1 || RESET_CYCLES > 15) $error("hsb_device: RESET_CYCLES out of range");
   end
   hsb_sync #(.WIDTH(`HSB_REG_SEL_W + `HSB_DATA_W + 6)) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     ({bus.register_select_lines, bus.host_data_lines, ~bus.register_select_strobe_n,
                  ~bus.shared_memory_request_n, bus.slave_address_latch, bus.bus_grant,
                  bus.bus_ordering_select, bus.slave_write}),
      .q_out    ({rsel_s, data_s, cs_s, shared_memory_request_s, sas_s, grant_s, order_s, swr_s})
   );
   assign slave_act = cs_s || shared_memory_request_s;
   assign master_act = (st_r == hsb_pkg::HSB_ADDR || st_r == hsb_pkg::HSB_STROBE);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_cnt_r <= '0;
      end else if (st_r == hsb_pkg::HSB_RST && rst_cnt_r != 4'(RESET_CYCLES)) begin
         rst_cnt_r <= rst_cnt_r + 4'h1;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         in_reset_out <= 1'b1;
      end else begin
         in_reset_out <= (rst_cnt_r != 4'(RESET_CYCLES));
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         big_endian_out <= 1'b0;
      end else begin
         big_endian_out <= order_s;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sel_r <= '0;
      end else if (sas_s) begin
         sel_r <= rsel_s;
      end
   end
   always_ff @(posedge clk_in) begin
      if (cs_s && swr_s && !in_reset_out) begin
         regs_r[sel_r] <= data_s[`HSB_HALF_W-1:0];
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r   <= hsb_pkg::HSB_RST;
         wr_r   <= 1'b0;
         wide_r <= 1'b0;
         wdat_r <= '0;
         addr_r <= '0;
      end else begin
         case (st_r)
            hsb_pkg::HSB_RST: begin
               if (rst_cnt_r == 4'(RESET_CYCLES)) st_r <= hsb_pkg::HSB_IDLE;
            end
            hsb_pkg::HSB_IDLE: begin
               if (dma_req_in && grant_s && !slave_act) begin
                  wr_r   <= dma_write_in;
                  wide_r <= dma_wide_in;
                  wdat_r <= dma_wdata_in;
                  addr_r <= dma_addr_in;
                  st_r   <= hsb_pkg::HSB_ADDR;
               end
            end
            hsb_pkg::HSB_ADDR:   st_r <= hsb_pkg::HSB_STROBE;
            hsb_pkg::HSB_STROBE: st_r <= hsb_pkg::HSB_DONE;
            hsb_pkg::HSB_DONE:   st_r <= hsb_pkg::HSB_IDLE;
            default:             st_r <= hsb_pkg::HSB_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.dma_address_lines <= '0;
      end else begin
         bus.dma_address_lines <= addr_r;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.dma_address_oe          <= 1'b0;
         bus.transfer_data_strobe_oe <= 1'b0;
      end else begin
         bus.dma_address_oe          <= master_act;
         bus.transfer_data_strobe_oe <= master_act;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.transfer_data_strobe_n <= 1'b1;
      end else begin
         bus.transfer_data_strobe_n <= !(st_r == hsb_pkg::HSB_ADDR);
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.dev_data_lo_oe <= 1'b0;
         bus.dev_data_hi_oe <= 1'b0;
      end else begin
         bus.dev_data_lo_oe <= (master_act && wr_r) || (cs_s && !swr_s && !in_reset_out);
         bus.dev_data_hi_oe <= master_act && wr_r && wide_r;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.dev_data <= '0;
      end else if (cs_s && !swr_s && st_r == hsb_pkg::HSB_IDLE) begin
         bus.dev_data <= {{`HSB_HALF_W{1'b0}}, regs_r[sel_r]};
      end else begin
         bus.dev_data <= wdat_r;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.slave_memory_ack_n <= 1'b1;
      end else begin
         bus.slave_memory_ack_n <= !(slave_act && st_r == hsb_pkg::HSB_IDLE);
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bus.bus_status_lines <= `HSB_STAT_RESET;
      end else begin
         case (st_r)
            hsb_pkg::HSB_RST:    bus.bus_status_lines <= `HSB_STAT_RESET;
            hsb_pkg::HSB_IDLE:   bus.bus_status_lines <= slave_act ? `HSB_STAT_SLAVE : `HSB_STAT_IDLE;
            default:             bus.bus_status_lines <= wr_r ? `HSB_STAT_MWRITE : `HSB_STAT_MREAD;
         endcase
      end
   end
   // dma completion to user side
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dma_done_out  <= 1'b0;
         dma_rdata_out <= '0;
      end else begin
         dma_done_out <= (st_r == hsb_pkg::HSB_STROBE);
         if (st_r == hsb_pkg::HSB_STROBE && !wr_r) begin
            dma_rdata_out <= wide_r ? data_s : {{`HSB_HALF_W{1'b0}}, data_s[`HSB_HALF_W-1:0]};
         end
      end
   end
endmodule // hsb_device

/* File: rtl/hsb_host.sv */
`timescale 1ns/10ps
`include "hsb_params.svh"
module hsb_host (
   // clock and reset
   input  wire logic                        clk_in,
   input  wire logic                        rst_n_in,
   // system bus
   hsb_if.host                              bus,
   // register access request
   input  wire logic                        acc_req_in,
   input  wire logic                        acc_mem_in,
   input  wire logic                        acc_write_in,
   input  wire logic [`HSB_REG_SEL_W-1:0]   acc_index_in,
   input  wire logic [`HSB_HALF_W-1:0]      acc_wdata_in,
   input  wire logic                        grant_in,
   input  wire logic                        big_endian_in,
   output logic                             acc_busy_out,
   output logic                             acc_done_out,
   output logic      [`HSB_HALF_W-1:0]      acc_rdata_out
);
   hsb_pkg::hsb_host_state_e st_r;
   logic [1:0]               gap_r;
   logic                     ack_s;
   logic                     owner_s;
   logic [`HSB_HALF_W-1:0]   rd_s;
   hsb_sync #(.WIDTH(`HSB_HALF_W + 2)) u_sync (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .d_in     ({bus.host_data_lines[`HSB_HALF_W-1:0], ~bus.slave_memory_ack_n, bus.dma_address_oe}),
      .q_out    ({rd_s, ack_s, owner_s})
   );
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r                         <= hsb_pkg::HSB_H_IDLE;
         gap_r                        <= '0;
         bus.register_select_lines    <= '0;
         bus.register_select_strobe_n <= 1'b1;
         bus.shared_memory_request_n  <= 1'b1;
         bus.slave_address_latch      <= 1'b0;
         bus.slave_write              <= 1'b0;
         bus.host_data                <= '0;
         bus.host_data_oe             <= 1'b0;
         bus.bus_grant                <= 1'b0;
         bus.bus_ordering_select      <= 1'b0;
         acc_busy_out                 <= 1'b0;
         acc_done_out                 <= 1'b0;
         acc_rdata_out                <= '0;
      end else begin
         bus.bus_grant           <= grant_in && (st_r == hsb_pkg::HSB_H_IDLE);
         bus.bus_ordering_select <= big_endian_in;
         acc_done_out            <= 1'b0;
         case (st_r)
            hsb_pkg::HSB_H_IDLE: begin
               if (acc_req_in && !grant_in && !owner_s) begin
                  bus.register_select_lines <= acc_index_in;
                  bus.slave_address_latch   <= 1'b1;
                  bus.slave_write           <= acc_write_in;
                  bus.host_data             <= {{`HSB_HALF_W{1'b0}}, acc_wdata_in};
                  bus.host_data_oe          <= acc_write_in;
                  acc_busy_out              <= 1'b1;
                  st_r                      <= hsb_pkg::HSB_H_LAT;
               end
            end
            hsb_pkg::HSB_H_LAT: begin
               bus.slave_address_latch <= 1'b0;
               if (acc_mem_in) begin
                  bus.shared_memory_request_n <= 1'b0;
               end else begin
                  bus.register_select_strobe_n <= 1'b0;
               end
               st_r <= hsb_pkg::HSB_H_WAIT;
            end
            hsb_pkg::HSB_H_WAIT: begin
               if (ack_s) begin
                  bus.register_select_strobe_n <= 1'b1;
                  bus.shared_memory_request_n  <= 1'b1;
                  bus.host_data_oe             <= 1'b0;
                  acc_rdata_out                <= rd_s;
                  gap_r                        <= 2'(`HSB_MEM_GAP);
                  st_r                         <= hsb_pkg::HSB_H_GAP;
               end
            end
            hsb_pkg::HSB_H_GAP: begin
               if (gap_r == 2'h0) begin
                  acc_busy_out <= 1'b0;
                  acc_done_out <= 1'b1;
                  st_r         <= hsb_pkg::HSB_H_IDLE;
               end else begin
                  gap_r <= gap_r - 2'h1;
               end
            end
            default: st_r <= hsb_pkg::HSB_H_IDLE;
         endcase
      end
   end
endmodule // hsb_host

/* File: rtl/hsb_sync.sv */
`timescale 1ns/10ps
module hsb_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // level in and out
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_r;
   initial begin
      if (WIDTH < 1) $error("hsb_sync: WIDTH must be at least 1");
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_r <= '0;
         q_out  <= '0;
      end else begin
         meta_r <= d_in;
         q_out  <= meta_r;
      end
   end
endmodule // hsb_sync

/* File: shared/hsb_if.sv */
`timescale 1ns/10ps
`include "hsb_params.svh"
interface hsb_if;
   // data lines
   logic [`HSB_DATA_W-1:0]    dev_data;
   logic [`HSB_DATA_W-1:0]    host_data;
   logic                      dev_data_lo_oe;
   logic                      dev_data_hi_oe;
   logic                      host_data_oe;
   // master address and strobes
   logic [`HSB_ADDR_W-1:0]    dma_address_lines;
   logic                      dma_address_oe;
   logic                      transfer_data_strobe_n;
   logic                      transfer_data_strobe_oe;
   logic                      bus_grant;
   // slave access
   logic [`HSB_REG_SEL_W-1:0] register_select_lines;
   logic                      register_select_strobe_n;
   logic                      slave_address_latch;
   logic                      slave_write;
   logic                      shared_memory_request_n;
   logic                      slave_memory_ack_n;
   // status and mode
   logic [`HSB_STAT_W-1:0]    bus_status_lines;
   logic                      bus_ordering_select;
   logic [`HSB_DATA_W-1:0]    host_data_lines;
   // wire level resolved from the enables
   always_comb begin
      host_data_lines = '0;
      if (dev_data_lo_oe) begin
         host_data_lines[`HSB_HALF_W-1:0] = dev_data[`HSB_HALF_W-1:0];
      end else if (host_data_oe) begin
         host_data_lines[`HSB_HALF_W-1:0] = host_data[`HSB_HALF_W-1:0];
      end
      if (dev_data_hi_oe) begin
         host_data_lines[`HSB_DATA_W-1:`HSB_HALF_W] = dev_data[`HSB_DATA_W-1:`HSB_HALF_W];
      end else if (host_data_oe) begin
         host_data_lines[`HSB_DATA_W-1:`HSB_HALF_W] = host_data[`HSB_DATA_W-1:`HSB_HALF_W];
      end
   end
   modport device (
      output dev_data, dev_data_lo_oe, dev_data_hi_oe, dma_address_lines, dma_address_oe,
             transfer_data_strobe_n, transfer_data_strobe_oe, slave_memory_ack_n, bus_status_lines,
      input  host_data_lines, bus_grant, register_select_lines, register_select_strobe_n,
             slave_address_latch, slave_write, shared_memory_request_n, bus_ordering_select
   );
   modport host (
      output host_data, host_data_oe, bus_grant, register_select_lines, register_select_strobe_n,
             slave_address_latch, slave_write, shared_memory_request_n, bus_ordering_select,
      input  host_data_lines, dma_address_lines, dma_address_oe, transfer_data_strobe_n,
             transfer_data_strobe_oe, slave_memory_ack_n, bus_status_lines
   );
endinterface // hsb_if

/* File: shared/hsb_params.svh */
`ifndef HSB_PARAMS_SVH
`define HSB_PARAMS_SVH
`define HSB_DATA_W        32
`define HSB_HALF_W        16
`define HSB_ADDR_W        31
`define HSB_REG_SEL_W     6
`define HSB_STAT_W        3
`define HSB_RESET_CYCLES  10
`define HSB_MEM_GAP       2
`define HSB_REG_COUNT     64
`define HSB_STAT_IDLE     3'h0
`define HSB_STAT_MREAD    3'h1
`define HSB_STAT_MWRITE   3'h2
`define HSB_STAT_SLAVE    3'h3
`define HSB_STAT_RESET    3'h7
`endif

/* File: shared/hsb_pkg.sv */
package hsb_pkg;
   typedef enum logic [2:0] {
      HSB_IDLE   = 3'b000,
      HSB_ADDR   = 3'b001,
      HSB_STROBE = 3'b010,
      HSB_DONE   = 3'b011,
      HSB_RST    = 3'b100
   } hsb_dev_state_e;
   typedef enum logic [1:0] {
      HSB_H_IDLE = 2'b00,
      HSB_H_LAT  = 2'b01,
      HSB_H_WAIT = 2'b10,
      HSB_H_GAP  = 2'b11
   } hsb_host_state_e;
endpackage

/* File: sim/hsb_checker.sv */
`timescale 1ns/10ps
`include "hsb_params.svh"
module hsb_checker (
   // clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   rst_n_in,
   // interface signals
   input  wire logic                   dev_data_lo_oe,
   input  wire logic                   dev_data_hi_oe,
   input  wire logic                   dma_address_oe,
   input  wire logic                   transfer_data_strobe_n,
   input  wire logic                   transfer_data_strobe_oe,
   input  wire logic                   bus_grant,
   input  wire logic                   register_select_strobe_n,
   input  wire logic                   shared_memory_request_n,
   input  wire logic                   slave_memory_ack_n,
   input  wire logic [`HSB_STAT_W-1:0] bus_status_lines
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_strobe_on;
      !transfer_data_strobe_n && transfer_data_strobe_oe;
   endsequence
   sequence s_req_start;
      $fell(register_select_strobe_n) || $fell(shared_memory_request_n);
   endsequence
   sequence s_req_end;
      $rose(register_select_strobe_n) || $rose(shared_memory_request_n);
   endsequence
   AST_LO_WIDE: assert property (s_strobe_on ##0 dev_data_hi_oe |-> dev_data_lo_oe)
      else $error("upper data lanes driven without lower lanes");
   AST_SLAVE_HI_FLOAT: assert property (!register_select_strobe_n |-> !dev_data_hi_oe)
      else $error("upper data lanes driven during slave access");
   AST_ADDR_OWNER: assert property (dma_address_oe |-> bus_grant)
      else $error("address driven without bus ownership");
   AST_NO_OVERLAP: assert property (!(!register_select_strobe_n && !shared_memory_request_n))
      else $error("select and memory request overlap");
   AST_GAP: assert property (s_req_end |-> (register_select_strobe_n && shared_memory_request_n) [*2])
      else $error("gap between select and memory request too short");
   AST_STROBE_PULSE: assert property (s_strobe_on |-> dma_address_oe ##1 transfer_data_strobe_n)
      else $error("data strobe not a single cycle under a valid address");
   AST_STATUS_MASTER: assert property (s_strobe_on |->
      (bus_status_lines == `HSB_STAT_MREAD || bus_status_lines == `HSB_STAT_MWRITE))
      else $error("status code wrong during master transfer");
   AST_ACK_CAUSE: assert property ($fell(slave_memory_ack_n) |->
      (!register_select_strobe_n || !shared_memory_request_n))
      else $error("acknowledge without select or memory request");
   AST_ACK_BOUND: assert property (s_req_start |-> ##[1:8] !slave_memory_ack_n)
      else $error("acknowledge late");
   AST_ACK_RELEASE: assert property (s_req_end |-> ##[1:6] slave_memory_ack_n)
      else $error("acknowledge not released");
   AST_FLOAT_IDLE: assert property (!dma_address_oe |-> !transfer_data_strobe_oe && !dev_data_hi_oe)
      else $error("master lines driven while not owner");
endmodule // hsb_checker

/* File: sim/tb_host_system_bus_interface.sv */
`timescale 1ns/10ps
`include "hsb_params.svh"
module tb_host_system_bus_interface;
   logic                      clk_in, rst_n_in, dma_req_in, dma_write_in, dma_wide_in;
   logic                      dma_done_out, in_reset_out, big_endian_out, grant_in, big_endian_in;
   logic                      acc_req_in, acc_mem_in, acc_write_in, acc_busy_out, acc_done_out;
   logic [`HSB_ADDR_W-1:0]    dma_addr_in, addr_seen;
   logic [`HSB_DATA_W-1:0]    dma_wdata_in, dma_rdata_out, data_seen;
   logic [`HSB_REG_SEL_W-1:0] acc_index_in;
   logic [`HSB_HALF_W-1:0]    acc_wdata_in, acc_rdata_out;
   logic [`HSB_STAT_W-1:0]    stat_seen;
   logic [5:0]                idx [3] = '{6'h00, 6'h3f, 6'h15};
   logic [15:0]               pat [3] = '{16'hffff, 16'h1234, 16'h8001};
   int                        fails, check_count;
   hsb_if i_hsb_if ();
   hsb_device i_hsb_device (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(i_hsb_if), .dma_req_in(dma_req_in),
      .dma_write_in(dma_write_in), .dma_wide_in(dma_wide_in), .dma_addr_in(dma_addr_in),
      .dma_wdata_in(dma_wdata_in), .dma_done_out(dma_done_out), .dma_rdata_out(dma_rdata_out),
      .in_reset_out(in_reset_out), .big_endian_out(big_endian_out));
   hsb_host i_hsb_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(i_hsb_if), .acc_req_in(acc_req_in),
      .acc_mem_in(acc_mem_in), .acc_write_in(acc_write_in), .acc_index_in(acc_index_in),
      .acc_wdata_in(acc_wdata_in), .grant_in(grant_in), .big_endian_in(big_endian_in),
      .acc_busy_out(acc_busy_out), .acc_done_out(acc_done_out), .acc_rdata_out(acc_rdata_out));
   hsb_checker i_hsb_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .dev_data_lo_oe(i_hsb_if.dev_data_lo_oe), .dev_data_hi_oe(i_hsb_if.dev_data_hi_oe),
      .dma_address_oe(i_hsb_if.dma_address_oe), .transfer_data_strobe_n(i_hsb_if.transfer_data_strobe_n),
      .transfer_data_strobe_oe(i_hsb_if.transfer_data_strobe_oe), .bus_grant(i_hsb_if.bus_grant),
      .register_select_strobe_n(i_hsb_if.register_select_strobe_n),
      .shared_memory_request_n(i_hsb_if.shared_memory_request_n),
      .slave_memory_ack_n(i_hsb_if.slave_memory_ack_n), .bus_status_lines(i_hsb_if.bus_status_lines));
   // capture what the bus carries while the data strobe is low
   always @(posedge clk_in) begin
      if (i_hsb_if.transfer_data_strobe_n === 1'b0 && i_hsb_if.transfer_data_strobe_oe === 1'b1) begin
         addr_seen <= i_hsb_if.dma_address_lines;
         data_seen <= i_hsb_if.host_data_lines;
         stat_seen <= i_hsb_if.bus_status_lines;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   function automatic logic pick(input int sel);
      case (sel)
         0: return acc_busy_out;
         1: return acc_done_out;
         2: return i_hsb_if.dma_address_oe;
         default: return dma_done_out;
      endcase
   endfunction
   task automatic wait_hi(input int sel);
      int n;
      n = 0;
      while (pick(sel) !== 1'b1 && n < 100) begin
         @(negedge clk_in);
         n++;
      end
      if (n >= 100) begin
         fails++;
         $display("unexpected at %0t: handshake %0d timed out", $time, sel);
      end
   endtask
   task automatic acc(input logic mem, input logic wr, input logic [5:0] ix, input logic [15:0] wd);
      @(negedge clk_in);
      acc_req_in = 1'b1;
      acc_mem_in = mem;
      acc_write_in = wr;
      acc_index_in = ix;
      acc_wdata_in = wd;
      wait_hi(0);
      acc_req_in = 1'b0;
      wait_hi(1);
   endtask
   task automatic dma(input logic wr, input logic wide, input logic [30:0] a, input logic [31:0] d);
      @(negedge clk_in);
      dma_req_in = 1'b1;
      dma_write_in = wr;
      dma_wide_in = wide;
      dma_addr_in = a;
      dma_wdata_in = d;
      wait_hi(2);
      dma_req_in = 1'b0;
      wait_hi(3);
      check({1'b0, addr_seen}, {1'b0, a}, "dma address");
      check(stat_seen, wr ? `HSB_STAT_MWRITE : `HSB_STAT_MREAD, "master status");
      if (wr) begin
         check(data_seen, wide ? d : {16'h0000, d[15:0]}, "write data lanes");
      end else begin
         check(dma_rdata_out, 32'h0000_0000, "released lanes read as zero");
      end
   endtask
   task automatic reset_check();
      rst_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      check(i_hsb_if.bus_status_lines, `HSB_STAT_RESET, "status in reset");
      check(i_hsb_if.dma_address_oe, 1'b0, "address floats in reset");
      rst_n_in = 1'b1;
      repeat (8) @(negedge clk_in);
      check(in_reset_out, 1'b1, "reset count running");
      repeat (8) @(negedge clk_in);
      check(in_reset_out, 1'b0, "reset count over");
      check(i_hsb_if.bus_status_lines, `HSB_STAT_IDLE, "idle status");
      $display("test reset ended");
   endtask
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      fails++;
      stop_test();
   end
   initial begin
      {rst_n_in, dma_req_in, dma_write_in, dma_wide_in, grant_in, big_endian_in} = '0;
      {acc_req_in, acc_mem_in, acc_write_in, acc_index_in, acc_wdata_in} = '0;
      dma_addr_in = '0;
      dma_wdata_in = '0;
      repeat (18) @(negedge clk_in);
      reset_check();
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, 1'b1, idx[i], pat[i]);
      end
      acc(1'b1, 1'b0, 6'h00, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         acc(1'b0, 1'b0, idx[i], 16'h0000);
         check(acc_rdata_out, pat[i], "register read back");
      end
      $display("test registers ended");
      big_endian_in = 1'b1;
      repeat (6) @(negedge clk_in);
      check(big_endian_out, 1'b1, "big endian selected");
      big_endian_in = 1'b0;
      repeat (6) @(negedge clk_in);
      check(big_endian_out, 1'b0, "little endian selected");
      grant_in = 1'b1;
      repeat (6) @(negedge clk_in);
      for (int k = 0; k < 4; k++) begin
         dma(k[0], k[1], 31'h4000_0001 ^ 31'(k * 31'h1357_9bdf), 32'hc33c_a55a ^ 32'(k));
      end
      grant_in = 1'b0;
      repeat (6) @(negedge clk_in);
      check(i_hsb_if.dma_address_oe, 1'b0, "address released");
      check(i_hsb_if.transfer_data_strobe_oe, 1'b0, "strobe released");
      $display("test master ended");
      reset_check();
      acc(1'b0, 1'b0, idx[1], 16'h0000);
      check(acc_rdata_out, pat[1], "register kept over reset");
      $display("test after reset ended");
      stop_test();
   end
endmodule // tb_host_system_bus_interface
